// >>> iib_core.sv
// How it works
// - Locked add of 1..16, written back
// - Immediate field holds increment minus one
// - Bus lock held from read to write
// - Zero flag set when sum is zero
// - Sign flag copies sum sign bit
// - Overflow flag on same-sign inputs, flipped sum
// - Port element read, stored at destination
// - Port address is 16-bit source word
// - Pointer decremented by 1, 2 or 4
// - Count register decremented by one
// - Source register left untouched
// - Overflow flag marks count reaching zero
`timescale 1ns/100ps
`default_nettype none
module iib_core (
   input  wire logic               CLK,
   input  wire logic               RESETN,
   input  wire logic               START,
   input  wire iib_pkg::iib_op_t   OPCODE,
   input  wire iib_pkg::iib_size_t SIZE,
   input  wire logic [3:0]         IMM_CODE,
   input  wire logic               SYS_MODE,
   input  wire logic [5:0]         FLAGS_IN,
   input  wire logic [31:0]        DST_PTR,
   input  wire logic [15:0]        SRC_PORT,
   input  wire logic [15:0]        COUNT_IN,
   output logic                    BUSY,
   output logic                    DONE,
   output logic [5:0]              FLAGS_OUT,
   output logic [31:0]             PTR_OUT,
   output logic [15:0]             COUNT_OUT,
   output logic                    WB_REGS,
   output logic                    TRAP_OVF,
   output logic                    TRAP_PRIV,
   output logic                    MEM_REQ,
   output logic                    MEM_WE,
   output logic                    MEM_LOCK,
   output logic [31:0]             MEM_ADDR,
   output logic [31:0]             MEM_WDATA,
   output iib_pkg::iib_size_t      MEM_SIZE,
   input  wire logic [31:0]        MEM_RDATA,
   input  wire logic               MEM_ACK,
   output logic                    IO_REQ,
   output logic [15:0]             IO_ADDR,
   output iib_pkg::iib_size_t      IO_SIZE,
   input  wire logic [31:0]        IO_RDATA,
   input  wire logic               IO_ACK,
   input  wire logic [7:0]         REG_ADDR,
   input  wire logic [31:0]        REG_WDATA,
   input  wire logic               REG_WR,
   input  wire logic               REG_RD,
   output logic [31:0]             REG_RDATA,
   output logic                    IRQ
);
   import iib_pkg::*;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LRD  = 3'b001,
      ST_LWR  = 3'b010,
      ST_IORD = 3'b011,
      ST_MWR  = 3'b100
   } iib_state_t;

   iib_state_t        st_q, st_d;         // Sequencer state
   iib_op_t           op_q, op_d;         // Operation in flight
   iib_size_t         sz_q, sz_d;         // Operand size
   logic [3:0]        imm_q, imm_d;       // Immediate field
   logic [31:0]       ptr_q, ptr_d;       // Destination pointer
   logic [15:0]       src_q, src_d;       // Port address copy
   logic [15:0]       cnt_q, cnt_d;       // Count copy
   logic [5:0]        fin_q, fin_d;       // Flags at issue
   logic [31:0]       opnd_q, opnd_d;     // Value read under lock
   logic [31:0]       res_q, res_d;       // Sum written back
   logic [2:0]        pend_q, pend_d;     // Z, S, V of the sum
   logic              busy_q, busy_d;
   logic              done_q, done_d;
   logic [5:0]        fout_q, fout_d;
   logic [31:0]       pout_q, pout_d;
   logic [15:0]       cout_q, cout_d;
   logic              wb_q, wb_d;
   logic              tovf_q, tovf_d;
   logic              tprv_q, tprv_d;
   logic              mreq_q, mreq_d;
   logic              mwe_q, mwe_d;
   logic              mlock_q, mlock_d;
   logic [31:0]       maddr_q, maddr_d;
   logic [31:0]       mwd_q, mwd_d;
   logic              ioreq_q, ioreq_d;
   logic [31:0]       ctrl_q, ctrl_d;     // Control register
   logic [EV_W-1:0]   sts_q, sts_d;       // Sticky events
   logic [EV_W-1:0]   msk_q, msk_d;       // Event mask
   logic [31:0]       rdat_q, rdat_d;     // Read data
   logic              irq_q, irq_d;
   logic [EV_W-1:0]   ev;                 // Events this cycle
   logic [EV_W-1:0]   clr;                // Write-one-clear bits

   iib_alu_if u_if ();
   iib_alu    u_alu (.a(u_if));

   // Feed the datapath
   assign u_if.operand = MEM_RDATA;
   assign u_if.size    = sz_q;
   assign u_if.addend  = {1'b0, imm_q} + 5'h01;
   assign u_if.ptr_in  = ptr_q;
   assign u_if.cnt_in  = cnt_q;

   // Sequencer next values
   always_comb begin
      st_d = st_q;   op_d = op_q;   sz_d = sz_q;   imm_d = imm_q;
      ptr_d = ptr_q; src_d = src_q; cnt_d = cnt_q; fin_d = fin_q;
      opnd_d = opnd_q; res_d = res_q; pend_d = pend_q;
      busy_d = busy_q; fout_d = fout_q; pout_d = pout_q;
      cout_d = cout_q; mreq_d = mreq_q; mwe_d = mwe_q;
      mlock_d = mlock_q; maddr_d = maddr_q; mwd_d = mwd_q;
      ioreq_d = ioreq_q;
      // Pulses default low
      done_d = 1'b0;
      wb_d   = 1'b0;
      tovf_d = 1'b0;
      tprv_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (START && OPCODE != OP_NONE) begin
               op_d  = OPCODE;
               sz_d  = SIZE;
               imm_d = IMM_CODE;
               ptr_d = DST_PTR;
               src_d = SRC_PORT;    // Copy only, never written back
               cnt_d = COUNT_IN;
               fin_d = FLAGS_IN;
               if (OPCODE == OP_LOCKED_MEMORY_INC) begin
                  // Locked read of the operand
                  maddr_d = DST_PTR;
                  mreq_d  = 1'b1;
                  mwe_d   = 1'b0;
                  mlock_d = 1'b1;
                  busy_d  = 1'b1;
                  st_d    = ST_LRD;
               end else if (!SYS_MODE) begin
                  // Normal mode: trap, no transfer
                  tprv_d = 1'b1;
                  done_d = 1'b1;
                  fout_d = FLAGS_IN;
               end else begin
                  ioreq_d = 1'b1;  // Port read
                  busy_d  = 1'b1;
                  st_d    = ST_IORD;
               end
            end
         end
         ST_LRD: begin
            if (MEM_ACK) begin
               // Sum goes back to the same address
               opnd_d = MEM_RDATA & sz_mask(sz_q);
               res_d  = u_if.sum;
               mwd_d  = u_if.sum;
               pend_d = {u_if.ovf, u_if.sign, u_if.zero};
               mwe_d  = 1'b1;
               st_d   = ST_LWR;
            end
         end
         ST_LWR: begin
            if (MEM_ACK) begin
               mreq_d  = 1'b0;
               mwe_d   = 1'b0;
               mlock_d = 1'b0;   // Lock ends with the store
               fout_d  = fin_q;  // C, D, H untouched
               fout_d[FLAG_Z] = pend_q[0];
               fout_d[FLAG_S] = pend_q[1];
               fout_d[FLAG_V] = pend_q[2];
               tovf_d  = pend_q[2] && ctrl_q[CTRL_OVF_TRAP_EN];
               done_d  = 1'b1;
               busy_d  = 1'b0;
               st_d    = ST_IDLE;
            end
         end
         ST_IORD: begin
            if (IO_ACK) begin
               // Store the element at the pointer
               ioreq_d = 1'b0;
               mreq_d  = 1'b1;
               mwe_d   = 1'b1;
               maddr_d = ptr_q;
               mwd_d   = IO_RDATA & sz_mask(sz_q);
               st_d    = ST_MWR;
            end
         end
         ST_MWR: begin
            if (MEM_ACK) begin
               mreq_d = 1'b0;
               mwe_d  = 1'b0;
               pout_d = u_if.ptr_dec;
               cout_d = u_if.cnt_dec;
               wb_d   = 1'b1;
               fout_d = fin_q;
               fout_d[FLAG_V] = u_if.cnt_zero;
               done_d = 1'b1;
               busy_d = 1'b0;
               st_d   = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         st_q <= ST_IDLE;     op_q <= OP_NONE;    sz_q <= SZ_BYTE;
         imm_q <= 4'h0;       ptr_q <= 32'h0000_0000;
         src_q <= 16'h0000;   cnt_q <= 16'h0000;  fin_q <= 6'h00;
         opnd_q <= 32'h0000_0000; res_q <= 32'h0000_0000;
         pend_q <= 3'h0;      busy_q <= 1'b0;     done_q <= 1'b0;
         fout_q <= 6'h00;     pout_q <= 32'h0000_0000;
         cout_q <= 16'h0000;  wb_q <= 1'b0;       tovf_q <= 1'b0;
         tprv_q <= 1'b0;      mreq_q <= 1'b0;     mwe_q <= 1'b0;
         mlock_q <= 1'b0;     maddr_q <= 32'h0000_0000;
         mwd_q <= 32'h0000_0000; ioreq_q <= 1'b0;
      end else begin
         st_q <= st_d;        op_q <= op_d;       sz_q <= sz_d;
         imm_q <= imm_d;      ptr_q <= ptr_d;
         src_q <= src_d;      cnt_q <= cnt_d;     fin_q <= fin_d;
         opnd_q <= opnd_d;    res_q <= res_d;
         pend_q <= pend_d;    busy_q <= busy_d;   done_q <= done_d;
         fout_q <= fout_d;    pout_q <= pout_d;
         cout_q <= cout_d;    wb_q <= wb_d;       tovf_q <= tovf_d;
         tprv_q <= tprv_d;    mreq_q <= mreq_d;   mwe_q <= mwe_d;
         mlock_q <= mlock_d;  maddr_q <= maddr_d;
         mwd_q <= mwd_d;      ioreq_q <= ioreq_d;
      end
   end

   // Register file next values; a new event beats its clear
   always_comb begin
      ev = 3'h0;
      ev[EV_DONE] = done_q;
      ev[EV_OVF]  = tovf_q;
      ev[EV_PRIV] = tprv_q;
      clr    = (REG_WR && REG_ADDR == ADDR_STATUS) ?
               REG_WDATA[EV_W-1:0] : 3'h0;
      ctrl_d = ctrl_q;
      msk_d  = msk_q;
      if (REG_WR && REG_ADDR == ADDR_CTRL) begin
         ctrl_d = REG_WDATA & 32'h0000_0001;
      end
      if (REG_WR && REG_ADDR == ADDR_MASK) begin
         msk_d = REG_WDATA[EV_W-1:0];
      end
      sts_d  = (sts_q & ~clr) | ev;
      irq_d  = |(sts_d & msk_d);
      rdat_d = 32'h0000_0000;
      if (REG_RD) begin
         case (REG_ADDR)
            ADDR_CTRL:   rdat_d = ctrl_q;
            ADDR_STATUS: rdat_d = {29'h0000_0000, sts_q};
            ADDR_MASK:   rdat_d = {29'h0000_0000, msk_q};
            ADDR_FLAGS:  rdat_d = {25'h000_0000, busy_q, fout_q};
            default:     rdat_d = 32'h0000_0000;
         endcase
      end
   end

   // Register file registers
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         ctrl_q <= CTRL_RST;
         sts_q  <= EV_RST;
         msk_q  <= EV_RST;
         rdat_q <= 32'h0000_0000;
         irq_q  <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         sts_q  <= sts_d;
         msk_q  <= msk_d;
         rdat_q <= rdat_d;
         irq_q  <= irq_d;
      end
   end

   // Outputs straight from flip-flops
   assign BUSY      = busy_q;
   assign DONE      = done_q;
   assign FLAGS_OUT = fout_q;
   assign PTR_OUT   = pout_q;
   assign COUNT_OUT = cout_q;
   assign WB_REGS   = wb_q;
   assign TRAP_OVF  = tovf_q;
   assign TRAP_PRIV = tprv_q;
   assign MEM_REQ   = mreq_q;
   assign MEM_WE    = mwe_q;
   assign MEM_LOCK  = mlock_q;
   assign MEM_ADDR  = maddr_q;
   assign MEM_WDATA = mwd_q;
   assign MEM_SIZE  = sz_q;
   assign IO_REQ    = ioreq_q;
   assign IO_ADDR   = src_q;
   assign IO_SIZE   = sz_q;
   assign REG_RDATA = rdat_q;
   assign IRQ       = irq_q;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   logic inc_done;   // Increment finished this cycle
   logic ind_done;   // Block step finished this cycle
   assign inc_done = DONE && op_q == OP_LOCKED_MEMORY_INC;
   assign ind_done = DONE && op_q == OP_PORT_INPUT_DESC && !TRAP_PRIV;

   sequence s_lock_read;
      st_q == ST_LRD && MEM_ACK;
   endsequence
   sequence s_locked_write;
      MEM_REQ && MEM_WE && MEM_LOCK;
   endsequence

   a_lock_held: assert property (
      s_lock_read |=> s_locked_write)
      else $error("lock dropped between read and write");
   a_same_addr: assert property (
      s_lock_read |=> MEM_ADDR == $past(MEM_ADDR))
      else $error("locked write went to another address");
   a_imm_decode: assert property (
      (st_q == ST_LWR) |-> ((res_q - opnd_q) & sz_mask(sz_q)) ==
         {28'h000_0000, imm_q} + 32'h0000_0001)
      else $error("increment is not field plus one");
   a_zero_flag: assert property (
      inc_done |-> FLAGS_OUT[FLAG_Z] == (res_q == 32'h0000_0000))
      else $error("zero flag wrong after increment");
   a_sign_flag: assert property (
      inc_done |-> FLAGS_OUT[FLAG_S] == sz_msb(res_q, sz_q))
      else $error("sign flag wrong after increment");
   a_ovf_flag: assert property (
      inc_done |-> FLAGS_OUT[FLAG_V] ==
         (!sz_msb(opnd_q, sz_q) && sz_msb(res_q, sz_q)))
      else $error("overflow flag wrong after increment");
   a_keep_flags: assert property (
      inc_done |-> FLAGS_OUT[FLAG_C] == fin_q[FLAG_C] &&
         FLAGS_OUT[FLAG_D] == fin_q[FLAG_D] &&
         FLAGS_OUT[FLAG_H] == fin_q[FLAG_H] &&
         TRAP_OVF == (FLAGS_OUT[FLAG_V] && ctrl_q[CTRL_OVF_TRAP_EN]))
      else $error("kept flags or overflow trap wrong");
   a_io_to_mem: assert property (
      (st_q == ST_IORD && IO_ACK) |=> MEM_REQ && MEM_WE &&
         MEM_ADDR == ptr_q && MEM_WDATA == ($past(IO_RDATA) &
         sz_mask(sz_q)))
      else $error("port element not stored at pointer");
   a_ptr_cnt: assert property (
      ind_done |-> PTR_OUT == ptr_q - sz_elem(sz_q) &&
         COUNT_OUT == cnt_q - 16'h0001 && WB_REGS)
      else $error("pointer or count step wrong");
   a_cnt_flag: assert property (
      ind_done |-> FLAGS_OUT[FLAG_V] == (COUNT_OUT == 16'h0000) &&
         FLAGS_OUT[FLAG_Z] == fin_q[FLAG_Z])
      else $error("count flag wrong after block step");
   a_priv_trap: assert property (
      (st_q == ST_IDLE && START && OPCODE == OP_PORT_INPUT_DESC &&
       !SYS_MODE) |=> TRAP_PRIV && DONE && !IO_REQ && !MEM_REQ)
      else $error("normal mode block input not trapped");
endmodule
`default_nettype wire

// >>> iib_pkg.sv
`default_nettype none
package iib_pkg;
   // Operand and element size
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10
   } iib_size_t;

   // Operation issued by the decoder
   typedef enum logic [1:0] {
      OP_NONE                = 2'b00,
      OP_LOCKED_MEMORY_INC   = 2'b01,
      OP_PORT_INPUT_DESC     = 2'b10
   } iib_op_t;

   // Flag vector layout
   localparam int FLAG_W = 6;
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_S = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_D = 4;
   localparam int FLAG_H = 5;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK   = 8'h08;
   localparam logic [7:0] ADDR_FLAGS  = 8'h0C;

   // Control bits and reset values
   localparam int CTRL_OVF_TRAP_EN   = 0;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
   localparam int EV_W               = 3;
   localparam int EV_DONE            = 0;
   localparam int EV_OVF             = 1;
   localparam int EV_PRIV            = 2;
   localparam logic [EV_W-1:0] EV_RST = 3'h0;

   // Data mask for a size
   function automatic logic [31:0] sz_mask(input iib_size_t s);
      case (s)
         SZ_BYTE: sz_mask = 32'h0000_00FF;
         SZ_WORD: sz_mask = 32'h0000_FFFF;
         default: sz_mask = 32'hFFFF_FFFF;
      endcase
   endfunction

   // Sign bit of a value at a size
   function automatic logic sz_msb(input logic [31:0] v,
                                   input iib_size_t s);
      case (s)
         SZ_BYTE: sz_msb = v[7];
         SZ_WORD: sz_msb = v[15];
         default: sz_msb = v[31];
      endcase
   endfunction

   // Pointer step for a size
   function automatic logic [31:0] sz_elem(input iib_size_t s);
      case (s)
         SZ_BYTE: sz_elem = 32'h0000_0001;
         SZ_WORD: sz_elem = 32'h0000_0002;
         default: sz_elem = 32'h0000_0004;
      endcase
   endfunction
endpackage
`default_nettype wire

// >>> iib_alu_if.sv
`timescale 1ns/100ps
`default_nettype none
interface iib_alu_if;
   logic [31:0]        operand;   // Memory operand before the add
   iib_pkg::iib_size_t size;      // Operand size
   logic [4:0]         addend;    // Increment value 1..16
   logic [31:0]        sum;       // Masked sum
   logic               zero;      // Sum is zero
   logic               sign;      // Sum is negative
   logic               ovf;       // Signed overflow
   logic [31:0]        ptr_in;    // Destination pointer
   logic [31:0]        ptr_dec;   // Pointer less one element
   logic [15:0]        cnt_in;    // Count register
   logic [15:0]        cnt_dec;   // Count less one
   logic               cnt_zero;  // Decremented count is zero
   modport core (output operand, size, addend, ptr_in, cnt_in,
                 input sum, zero, sign, ovf, ptr_dec, cnt_dec, cnt_zero);
   modport alu  (input operand, size, addend, ptr_in, cnt_in,
                 output sum, zero, sign, ovf, ptr_dec, cnt_dec, cnt_zero);
endinterface
`default_nettype wire

// >>> iib_alu.sv
`timescale 1ns/100ps
`default_nettype none
module iib_alu (
   iib_alu_if.alu a
);
   import iib_pkg::*;
   logic [31:0] raw;   // Unmasked sum
   logic        a_s;   // Sign of memory operand
   logic        b_s;   // Sign of addend
   // Two's complement add, cut back to the operand size
   always_comb begin
      raw    = a.operand + {27'h000_0000, a.addend};
      a.sum  = raw & sz_mask(a.size);
      a.zero = (a.sum == 32'h0000_0000);
      a.sign = sz_msb(a.sum, a.size);
      a_s    = sz_msb(a.operand, a.size);
      b_s    = sz_msb({27'h000_0000, a.addend}, a.size);
      // Same signs in, other sign out
      a.ovf  = (a_s == b_s) && (a.sign != a_s);
   end
   // Pointer and count steps of the block input
   always_comb begin
      a.ptr_dec  = a.ptr_in - sz_elem(a.size);
      a.cnt_dec  = a.cnt_in - 16'h0001;
      a.cnt_zero = (a.cnt_dec == 16'h0000);
   end
endmodule
`default_nettype wire

// >>> iib_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module iib_mem_model (
   input  wire logic        CLK,
   input  wire logic        RESETN,
   input  wire logic        SLOW,
   input  wire logic        MEM_REQ,
   input  wire logic        MEM_WE,
   input  wire logic [31:0] MEM_ADDR,
   input  wire logic [31:0] MEM_WDATA,
   output var  logic [31:0] MEM_RDATA,
   output var  logic        MEM_ACK,
   input  wire logic        IO_REQ,
   input  wire logic [15:0] IO_ADDR,
   output var  logic [31:0] IO_RDATA,
   output var  logic        IO_ACK
);
   logic [31:0] mem [logic [31:0]]; // Sparse word store, loaded by the bench
   int          mcnt;               // Wait cycles, memory side
   int          icnt;               // Wait cycles, port side
   logic        mgo;                // Memory answers at this edge
   logic        igo;                // Port answers at this edge
   // Known start; idle data toggles so a stale value never looks valid
   initial begin
      MEM_RDATA = 32'h0000_0000;
      IO_RDATA = 32'h0000_0000;
      MEM_ACK = 1'b0;
      IO_ACK = 1'b0;
   end
   // Memory: answers after one or four cycles, stores on a write
   always @(posedge CLK) begin
      mgo = RESETN && MEM_REQ && !MEM_ACK && (mcnt >= (SLOW ? 3 : 0));
      mcnt = (RESETN && MEM_REQ && !MEM_ACK && !mgo) ? mcnt + 1 : 0;
      if (mgo && MEM_WE) begin
         mem[MEM_ADDR] = MEM_WDATA;
      end
      MEM_RDATA <= (mgo && !MEM_WE) ? mem[MEM_ADDR] : ~MEM_RDATA;
      MEM_ACK <= mgo;
   end
   // Port space: data is a pattern of the 16-bit port address
   always @(posedge CLK) begin
      igo = RESETN && IO_REQ && !IO_ACK && (icnt >= (SLOW ? 3 : 0));
      icnt = (RESETN && IO_REQ && !IO_ACK && !igo) ? icnt + 1 : 0;
      IO_RDATA <= igo ? {~IO_ADDR, IO_ADDR} : ~IO_RDATA;
      IO_ACK <= igo;
   end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import iib_pkg::*;
   typedef struct {
      logic [5:0]  fl;
      logic        ov, pv, wb;
      logic [1:0]  sz;
      logic [31:0] ptr, wd, ad;
      logic [15:0] cnt, ioa;
      int          nw, nl, nio;
   } iib_note_t;
   logic        CLK = 1'b0, RESETN = 1'b0, START = 1'b0;
   logic        SYS_MODE = 1'b1, SLOW = 1'b0;
   logic        REG_WR = 1'b0, REG_RD = 1'b0;
   iib_op_t     OPCODE = OP_NONE;
   iib_size_t   SIZE = SZ_BYTE;
   logic [3:0]  IMM_CODE = 4'h0;
   logic [5:0]  FLAGS_IN = 6'h00;
   logic [7:0]  REG_ADDR = 8'h00;
   logic [31:0] DST_PTR = '0, REG_WDATA = '0;
   logic [15:0] SRC_PORT = 16'h0000, COUNT_IN = 16'h0000;
   logic        BUSY, DONE, WB_REGS, TRAP_OVF, TRAP_PRIV, IRQ;
   logic        MEM_REQ, MEM_WE, MEM_LOCK, MEM_ACK, IO_REQ, IO_ACK;
   logic [5:0]  FLAGS_OUT;
   logic [31:0] PTR_OUT, MEM_ADDR, MEM_WDATA, MEM_RDATA;
   logic [31:0] IO_RDATA, REG_RDATA;
   logic [15:0] COUNT_OUT, IO_ADDR;
   iib_size_t   MEM_SIZE, IO_SIZE;
   iib_note_t   nq[$];          // Expected operation results
   logic [31:0] rq[$];          // Expected read data
   int          n_mismatch = 0, compares = 0;
   int          nw, nl, nio;    // Bus events seen in this operation
   logic [31:0] wd;             // Last data written to memory
   logic [15:0] ioa;            // Last port address answered
   logic        rdp = 1'b0;     // Read issued at the previous edge
   logic        tren = 1'b1;    // Overflow trap enabled
   iib_note_t   e;
   // Clock
   always #2.5 CLK = ~CLK;
   iib_core DUT (.CLK(CLK), .RESETN(RESETN), .START(START),
      .OPCODE(OPCODE), .SIZE(SIZE), .IMM_CODE(IMM_CODE),
      .SYS_MODE(SYS_MODE), .FLAGS_IN(FLAGS_IN), .DST_PTR(DST_PTR),
      .SRC_PORT(SRC_PORT), .COUNT_IN(COUNT_IN), .BUSY(BUSY), .DONE(DONE),
      .FLAGS_OUT(FLAGS_OUT), .PTR_OUT(PTR_OUT), .COUNT_OUT(COUNT_OUT),
      .WB_REGS(WB_REGS), .TRAP_OVF(TRAP_OVF), .TRAP_PRIV(TRAP_PRIV),
      .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_LOCK(MEM_LOCK),
      .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_SIZE(MEM_SIZE),
      .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .IO_REQ(IO_REQ),
      .IO_ADDR(IO_ADDR), .IO_SIZE(IO_SIZE), .IO_RDATA(IO_RDATA),
      .IO_ACK(IO_ACK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
   iib_mem_model pm (.CLK(CLK), .RESETN(RESETN), .SLOW(SLOW),
      .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
      .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK),
      .IO_REQ(IO_REQ), .IO_ADDR(IO_ADDR), .IO_RDATA(IO_RDATA),
      .IO_ACK(IO_ACK));
   // Compare one value
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // Verdict and end of run
   task automatic end_of_test();
      if (n_mismatch == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Sign bit at a size
   function automatic logic msb(input logic [31:0] v, input int sz);
      return (sz == 0) ? v[7] : (sz == 1) ? v[15] : v[31];
   endfunction
   // Watcher: bus events, read data and results at DONE
   always @(posedge CLK) begin
      rdp <= REG_RD;
      if (rdp) chk(REG_RDATA, rq.pop_front());
      if (MEM_ACK === 1'b1) begin
         chk(MEM_ADDR, nq[0].ad);
         chk({BUSY, MEM_SIZE}, {1'b1, nq[0].sz});
      end
      if (IO_ACK === 1'b1) chk(IO_SIZE, nq[0].sz);
      if (MEM_ACK === 1'b1 && MEM_WE === 1'b1) begin
         wd = MEM_WDATA;
         nw++;
      end
      if (MEM_ACK === 1'b1 && MEM_LOCK === 1'b1) nl++;
      if (IO_ACK === 1'b1) begin
         ioa = IO_ADDR;
         nio++;
      end
      if (DONE === 1'b1 && nq.size() == 0) begin
         chk(32'h0, 32'h1);
      end else if (DONE === 1'b1) begin
         e = nq.pop_front();
         chk(FLAGS_OUT, e.fl);
         chk(TRAP_OVF, e.ov);
         chk(TRAP_PRIV, e.pv);
         chk(WB_REGS, e.wb);
         chk(32'(nw), 32'(e.nw));
         chk(32'(nio), 32'(e.nio));
         chk(32'(nl), 32'(e.nl));
         if (e.nw != 0) chk(wd, e.wd);
         if (e.nio != 0) chk(ioa, e.ioa);
         if (e.wb) chk(PTR_OUT, e.ptr);
         if (e.wb) chk(COUNT_OUT, e.cnt);
         nw = 0;
         nl = 0;
         nio = 0;
      end
   end
   // Register write, then one idle cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      REG_ADDR <= a;
      REG_WDATA <= v;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
      @(posedge CLK);
   endtask
   // Register read; the watcher checks the data
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      rq.push_back(x);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      @(posedge CLK);
   endtask
   // Issue one operation, note its result, wait for DONE
   task automatic run(input iib_op_t op, input int sz, input logic [3:0] imm,
                      input logic sys, input logic [31:0] v,
                      input logic [15:0] cnt);
      iib_note_t   n;
      logic [31:0] m, s, d;
      logic [15:0] src;
      int          i;
      m = (sz == 0) ? 32'h0000_00FF : (sz == 1) ? 32'h0000_FFFF : '1;
      d = $urandom;
      src = 16'($urandom);
      n = '{default: 0};
      n.fl = 6'($urandom);
      n.ad = d;
      n.sz = 2'(sz);
      if (op == OP_LOCKED_MEMORY_INC) begin
         v = (v & m) | ($urandom & ~m);
         pm.mem[d] = v;
         s = (v + 32'(imm) + 32'h1) & m;
         n.fl[FLAG_Z] = (s == '0);
         n.fl[FLAG_S] = msb(s, sz);
         n.fl[FLAG_V] = !msb(v, sz) && msb(s, sz);
         n.ov = n.fl[FLAG_V] && tren;
         n.wd = s;
         n.nw = 1;
         n.nl = 2;
      end else if (sys) begin
         n.wd = {~src, src} & m;
         n.ioa = src;
         n.ptr = d - ((sz == 0) ? 1 : (sz == 1) ? 2 : 4);
         n.cnt = cnt - 16'h1;
         n.fl[FLAG_V] = (n.cnt == 16'h0000);
         n.wb = 1'b1;
         n.nw = 1;
         n.nio = 1;
      end else begin
         n.pv = 1'b1;
      end
      nq.push_back(n);
      OPCODE <= op;
      SIZE <= iib_size_t'(sz);
      IMM_CODE <= imm;
      SYS_MODE <= sys;
      // Flags due to change start from the opposite value
      FLAGS_IN <= n.fl ^ ((op == OP_LOCKED_MEMORY_INC) ? 6'h0E :
                          sys ? 6'h08 : 6'h00);
      DST_PTR <= d;
      SRC_PORT <= src; // Separate registers, never overlapping
      COUNT_IN <= cnt;
      SLOW <= 1'($urandom);
      START <= 1'b1;
      @(posedge CLK);
      START <= 1'b0;
      i = 0;
      do begin
         @(posedge CLK);
         i++;
      end while (DONE !== 1'b1 && i < 60);
      if (i >= 60) begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   // Main sequence
   initial begin
      void'($urandom(38));
      repeat (3) @(posedge CLK);
      RESETN <= 1'b1;
      rd(ADDR_CTRL, 32'h0000_0001);
      rd(ADDR_MASK, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      wr(ADDR_FLAGS, 32'hFFFF_FFFF);
      rd(ADDR_FLAGS, 32'h0000_0000);
      for (int sz = 0; sz < 3; sz++) begin
         m_loop(sz);
      end
      wr(ADDR_CTRL, 32'h0000_0000);
      tren = 1'b0;
      run(OP_LOCKED_MEMORY_INC, 0, 4'h0, 1'b1, 32'h7F, 16'h0);
      wr(ADDR_CTRL, 32'h0000_0001);
      tren = 1'b1;
      run(OP_PORT_INPUT_DESC, 1, 4'h0, 1'b0, '0, 16'h5);
      wr(ADDR_STATUS, 32'h0000_0007);
      wr(ADDR_MASK, 32'h0000_0002);
      run(OP_LOCKED_MEMORY_INC, 1, 4'h0, 1'b1, '0, 16'h0);
      @(posedge CLK);
      chk(IRQ, 32'h0);
      rd(ADDR_STATUS, 32'h0000_0001);
      run(OP_LOCKED_MEMORY_INC, 2, 4'hF, 1'b1, 32'h7FFF_FFF0, 16'h0);
      @(posedge CLK);
      chk(IRQ, 32'h1);
      rd(ADDR_STATUS, 32'h0000_0003);
      wr(ADDR_STATUS, 32'h0000_0002);
      chk(IRQ, 32'h0);
      wr(ADDR_MASK, 32'h0000_0001);
      chk(IRQ, 32'h1);
      end_of_test();
   end
   // Increments at the sign and zero edges, then block steps, for one size
   task automatic m_loop(input int sz);
      logic [31:0] mx;
      mx = (sz == 0) ? 32'h7F : (sz == 1) ? 32'h7FFF : 32'h7FFF_FFFF;
      run(OP_LOCKED_MEMORY_INC, sz, 4'h0, 1'b1, mx, 16'h0);
      run(OP_LOCKED_MEMORY_INC, sz, 4'h0, 1'b1, '1, 16'h0);
      run(OP_LOCKED_MEMORY_INC, sz, 4'hF, 1'b1, mx - 15, 16'h0);
      run(OP_LOCKED_MEMORY_INC, sz, 4'($urandom), 1'b1, $urandom, 16'h0);
      run(OP_PORT_INPUT_DESC, sz, 4'h0, 1'b1, '0, 16'h0001);
      run(OP_PORT_INPUT_DESC, sz, 4'h0, 1'b1, '0, 16'h0000);
      run(OP_PORT_INPUT_DESC, sz, 4'h0, 1'b1, '0, 16'($urandom));
   endtask
endmodule
`default_nettype wire
